// >>> mpu_pkg.sv
package mpu_pkg;

   typedef enum logic [2:0] {
      CL_BIT_TEST, CL_BIT_MOD, CL_BRANCH, CL_RMW, CL_CONTROL, CL_CALL, CL_OTHER
   } class_t;

   typedef enum logic [2:0] {
      FORM_DIR, FORM_ACC, FORM_IDX, FORM_IX1, FORM_IX0, FORM_INH
   } form_t;

   localparam int          PC_W        = 13;
   localparam int          MA_W        = 9;

   localparam logic [3:0]  HI_BIT_TEST = 4'h0;
   localparam logic [3:0]  HI_BIT_MOD  = 4'h1;
   localparam logic [3:0]  HI_BRANCH   = 4'h2;
   localparam logic [3:0]  HI_RMW_DIR  = 4'h3;
   localparam logic [3:0]  HI_RMW_ACC  = 4'h4;
   localparam logic [3:0]  HI_RMW_IDX  = 4'h5;
   localparam logic [3:0]  HI_RMW_IX1  = 4'h6;
   localparam logic [3:0]  HI_RMW_IX0  = 4'h7;
   localparam logic [3:0]  HI_CTL_A    = 4'h8;
   localparam logic [3:0]  HI_CTL_B    = 4'h9;

   localparam logic [3:0]  FN_NEGATE    = 4'h0;
   localparam logic [3:0]  FN_COM       = 4'h3;
   localparam logic [3:0]  FN_SHR       = 4'h4;
   localparam logic [3:0]  FN_ROT_R     = 4'h6;
   localparam logic [3:0]  FN_SHR_ARITH = 4'h7;
   localparam logic [3:0]  FN_SHL       = 4'h8;
   localparam logic [3:0]  FN_ROT_L     = 4'h9;
   localparam logic [3:0]  FN_MINUS_ONE = 4'hA;
   localparam logic [3:0]  FN_INC       = 4'hC;
   localparam logic [3:0]  FN_TEST      = 4'hD;
   localparam logic [3:0]  FN_ZERO      = 4'hF;

   localparam logic [3:0]  COND_ALWAYS = 4'h0;
   localparam logic [3:0]  COND_NEVER  = 4'h1;
   localparam logic [3:0]  COND_IRQ_LO = 4'hE;
   localparam logic [3:0]  COND_IRQ_HI = 4'hF;

   localparam logic [7:0]  OP_RET_INT  = 8'h80;
   localparam logic [7:0]  OP_RTS      = 8'h81;
   localparam logic [7:0]  OP_TRAP     = 8'h83;
   localparam logic [7:0]  OP_STOP     = 8'h8E;
   localparam logic [7:0]  OP_WAIT     = 8'h8F;
   localparam logic [7:0]  OP_A_TO_X   = 8'h97;
   localparam logic [7:0]  OP_CARRY0   = 8'h98;
   localparam logic [7:0]  OP_CARRY1   = 8'h99;
   localparam logic [7:0]  OP_MASK0    = 8'h9A;
   localparam logic [7:0]  OP_MASK1    = 8'h9B;
   localparam logic [7:0]  OP_SP_RESET = 8'h9C;
   localparam logic [7:0]  OP_IDLE     = 8'h9D;
   localparam logic [7:0]  OP_X_TO_A   = 8'h9F;
   localparam logic [7:0]  OP_BSR      = 8'hAD;

   localparam logic [7:0]  SP_INIT     = 8'h7F;
   localparam logic [7:0]  ACC_RESET   = 8'h00;
   localparam logic [7:0]  IDX_RESET   = 8'h00;
   localparam logic        MASK_RESET  = 1'b1;

endpackage : mpu_pkg

// >>> rmw_alu.sv
`timescale 1ns/1ps
module rmw_alu (
   input  wire logic [3:0] fn,
   input  wire logic [7:0] val,
   input  wire logic       c_in,
   output logic      [7:0] res,
   output logic            c_out,
   output logic            c_wr,
   output logic            wr_back,
   output logic            legal
);
   import mpu_pkg::*;

   always_comb begin
      res     = val;
      c_out   = c_in;
      c_wr    = 1'b0;
      wr_back = 1'b1;
      legal   = 1'b1;
      unique case (fn)
         FN_NEGATE: begin
            res   = 8'h00 - val;
            c_out = (val != 8'h00);
            c_wr  = 1'b1;
         end
         FN_COM: begin
            res   = ~val;
            c_out = 1'b1;
            c_wr  = 1'b1;
         end
         FN_SHR: begin res = {1'b0, val[7:1]};   c_out = val[0]; c_wr = 1'b1; end
         FN_ROT_R: begin res = {c_in, val[7:1]};   c_out = val[0]; c_wr = 1'b1; end
         FN_SHR_ARITH: begin res = {val[7], val[7:1]}; c_out = val[0]; c_wr = 1'b1; end
         FN_SHL: begin res = {val[6:0], 1'b0};   c_out = val[7]; c_wr = 1'b1; end
         FN_ROT_L: begin res = {val[6:0], c_in};   c_out = val[7]; c_wr = 1'b1; end
         FN_MINUS_ONE: res = val - 8'h01;
         FN_INC: res = val + 8'h01;
         FN_TEST: wr_back = 1'b0;
         FN_ZERO: res = 8'h00;
         default: begin
            wr_back = 1'b0;
            legal   = 1'b0;
         end
      endcase
   end

endmodule : rmw_alu

// >>> mpu_exec_core.sv
`timescale 1ns/1ps
module mpu_exec_core (
   input  wire logic                      sys_clk,
   input  wire logic                      rst_n,
   input  wire logic                      instr_valid,
   input  wire logic [7:0]                opcode,
   input  wire logic [7:0]                ea_in,
   input  wire logic [7:0]                rel_in,
   input  wire logic [mpu_pkg::PC_W-1:0]  pc_next_in,
   input  wire logic                      irq_line,
   input  wire logic [7:0]                mem_rdata,
   output logic                           instr_ready,
   output logic                           instr_done,
   output logic      [mpu_pkg::PC_W-1:0]  pc_out,
   output logic                           branch_taken,
   output logic                           mem_rd,
   output logic                           mem_wr,
   output logic      [mpu_pkg::MA_W-1:0]  mem_addr,
   output logic      [7:0]                mem_wdata,
   output logic      [7:0]                acc,
   output logic      [7:0]                idx,
   output logic      [7:0]                sp,
   output logic      [4:0]                ccr,
   output logic                           trap_req,
   output logic                           ret_sub_req,
   output logic                           ret_int_req,
   output logic                           stop_req,
   output logic                           wait_req,
   output logic                           unsupported
);
   import mpu_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_DECODE, ST_READ, ST_EXEC, ST_WRITE, ST_DONE} state_t;

   state_t          state_q, state_d;
   logic [7:0]      op_q, ea_q, rel_q, acc_q, idx_q, sp_q, wdata_q;
   logic [PC_W-1:0] pcn_q, pc_q;
   logic [MA_W-1:0] addr_q;
   class_t          cls_q;
   form_t           form_q;
   logic            h_q, i_q, n_q, z_q, c_q, taken_q;
   logic [5:0]      pulse_q, pulse_d;

   // Decoding happens on the latched opcode so the input bus may move on.
   wire logic [3:0] hi = op_q[7:4];
   wire logic [3:0] lo = op_q[3:0];
   wire logic       is_rmw = (hi >= HI_RMW_DIR) && (hi <= HI_RMW_IX0);
   wire logic       is_ctl = (hi == HI_CTL_A) || (hi == HI_CTL_B);
   wire class_t     cls_w  = (hi == HI_BIT_TEST) ? CL_BIT_TEST :
                             (hi == HI_BIT_MOD)  ? CL_BIT_MOD  :
                             (hi == HI_BRANCH)   ? CL_BRANCH   :
                             is_rmw              ? CL_RMW      :
                             is_ctl              ? CL_CONTROL  :
                             (op_q == OP_BSR)    ? CL_CALL     : CL_OTHER;
   wire form_t      form_w = (hi == HI_RMW_ACC) ? FORM_ACC :
                             (hi == HI_RMW_IDX) ? FORM_IDX :
                             (hi == HI_RMW_IX1) ? FORM_IX1 :
                             (hi == HI_RMW_IX0) ? FORM_IX0 :
                             (is_rmw || hi <= HI_BIT_MOD) ? FORM_DIR : FORM_INH;
   wire logic [MA_W-1:0] eff_addr =
      (form_w == FORM_IX1) ? {1'b0, ea_q} + {1'b0, idx_q} :
      (form_w == FORM_IX0) ? {1'b0, idx_q} : {1'b0, ea_q};
   wire logic       need_read = (form_w == FORM_DIR) || (form_w == FORM_IX1)
                                || (form_w == FORM_IX0);

   // Operand selection and read-modify-write datapath.
   wire logic       rmw_mem = (cls_q == CL_RMW) && (form_q != FORM_ACC) && (form_q != FORM_IDX);
   wire logic [7:0] rmw_src = (form_q == FORM_ACC) ? acc_q :
                              (form_q == FORM_IDX) ? idx_q : mem_rdata;
   logic [7:0] alu_res;
   logic       alu_c, alu_cwr, alu_wb, alu_legal;

   rmw_alu u_alu (
      .fn      (lo),
      .val     (rmw_src),
      .c_in    (c_q),
      .res     (alu_res),
      .c_out   (alu_c),
      .c_wr    (alu_cwr),
      .wr_back (alu_wb),
      .legal   (alu_legal)
   );

   // Bit manipulation on the low page.
   wire logic [2:0] bit_sel  = op_q[3:1];
   wire logic [7:0] bit_mask = 8'h01 << bit_sel;
   wire logic       tested   = mem_rdata[bit_sel];
   wire logic [7:0] bit_val  = op_q[0] ? (mem_rdata & ~bit_mask) : (mem_rdata | bit_mask);
   wire logic       bit_hit  = tested ^ op_q[0];

   // Branch conditions, indexed by the low opcode nibble.
   wire logic [15:0] cond_vec = {irq_line, ~irq_line, i_q, ~i_q,
                                 n_q, ~n_q, h_q, ~h_q,
                                 z_q, ~z_q, c_q, ~c_q,
                                 c_q | z_q, ~(c_q | z_q), 1'b0, 1'b1};
   wire logic       take = ((cls_q == CL_BRANCH) && cond_vec[lo]) ||
                           ((cls_q == CL_BIT_TEST) && bit_hit) || (cls_q == CL_CALL);
   wire logic [PC_W-1:0] target = pcn_q + {{(PC_W-8){rel_q[7]}}, rel_q};

   wire logic       exec_st = (state_q == ST_EXEC);
   wire logic       do_write = (cls_q == CL_BIT_MOD) || (rmw_mem && alu_wb);
   wire logic       ctl = exec_st && (cls_q == CL_CONTROL);
   wire logic       rmw_ok = exec_st && (cls_q == CL_RMW) && alu_legal;
   wire logic       bad = (cls_q == CL_OTHER) || ((cls_q == CL_RMW) && !alu_legal)
                          || ((cls_q == CL_CONTROL) && !(op_q inside {OP_RET_INT, OP_RTS,
                          OP_TRAP, OP_STOP, OP_WAIT, OP_A_TO_X, OP_CARRY0, OP_CARRY1,
                          OP_MASK0, OP_MASK1, OP_SP_RESET, OP_IDLE, OP_X_TO_A}));

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE:   if (instr_valid) state_d = ST_DECODE;
         ST_DECODE: state_d = need_read ? ST_READ : ST_EXEC;
         ST_READ:   state_d = ST_EXEC;
         ST_EXEC:   state_d = do_write ? ST_WRITE : ST_DONE;
         ST_WRITE:  state_d = ST_DONE;
         ST_DONE:   state_d = ST_IDLE;
      endcase
   end

   // Control requests leave the core as pulses; stacking is done by the sequencer.
   assign pulse_d = exec_st ? {bad, op_q == OP_WAIT,
                               op_q == OP_STOP, op_q == OP_RET_INT, op_q == OP_RTS,
                               op_q == OP_TRAP} & {1'b1, {5{cls_q == CL_CONTROL}}}
                             : 6'h00;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) state_q <= ST_IDLE;
      else        state_q <= state_d;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         op_q  <= 8'h00;
         ea_q  <= 8'h00;
         rel_q <= 8'h00;
         pcn_q <= '0;
      end else if (state_q == ST_IDLE && instr_valid) begin
         op_q  <= opcode;
         ea_q  <= ea_in;
         rel_q <= rel_in;
         pcn_q <= pc_next_in;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cls_q  <= CL_OTHER;
         form_q <= FORM_INH;
         addr_q <= '0;
      end else if (state_q == ST_DECODE) begin
         cls_q  <= cls_w;
         form_q <= form_w;
         addr_q <= eff_addr;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_q    <= '0;
         taken_q <= 1'b0;
         wdata_q <= 8'h00;
         pulse_q <= 6'h00;
      end else begin
         pulse_q <= pulse_d;
         if (exec_st) begin
            pc_q    <= take ? target : pcn_q;
            taken_q <= take;
            wdata_q <= (cls_q == CL_BIT_MOD) ? bit_val : alu_res;
         end
      end
   end

   // A register operand is written back here; memory operands go out in ST_WRITE.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= ACC_RESET;
         idx_q <= IDX_RESET;
         sp_q  <= SP_INIT;
      end else begin
         if ((rmw_ok && alu_wb && form_q == FORM_ACC) || (ctl && op_q == OP_X_TO_A))
            acc_q <= (cls_q == CL_RMW) ? alu_res : idx_q;
         if ((rmw_ok && alu_wb && form_q == FORM_IDX) || (ctl && op_q == OP_A_TO_X))
            idx_q <= (cls_q == CL_RMW) ? alu_res : acc_q;
         if (ctl && op_q == OP_SP_RESET) sp_q <= SP_INIT;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         {h_q, n_q, z_q, c_q} <= 4'h0;
         i_q <= MASK_RESET;
      end else begin
         if (rmw_ok) begin
            n_q <= alu_res[7];
            z_q <= (alu_res == 8'h00);
            if (alu_cwr) c_q <= alu_c;
         end
         if (exec_st && cls_q == CL_BIT_TEST) c_q <= tested;
         if (ctl && op_q == OP_CARRY1) c_q <= 1'b1;
         if (ctl && op_q == OP_CARRY0) c_q <= 1'b0;
         if (ctl && (op_q == OP_MASK1 || op_q == OP_TRAP)) i_q <= 1'b1;
         if (ctl && (op_q == OP_MASK0 || op_q == OP_WAIT)) i_q <= 1'b0;
      end
   end

   assign instr_ready  = (state_q == ST_IDLE);
   assign instr_done   = (state_q == ST_DONE);
   assign mem_rd       = (state_q == ST_READ);
   assign mem_wr       = (state_q == ST_WRITE);
   assign mem_addr     = addr_q;
   assign mem_wdata    = wdata_q;
   assign pc_out       = pc_q;
   assign branch_taken = taken_q;
   assign acc          = acc_q;
   assign idx          = idx_q;
   assign sp           = sp_q;
   assign ccr          = {h_q, i_q, n_q, z_q, c_q};
   assign {unsupported, wait_req, stop_req, ret_int_req, ret_sub_req, trap_req} = pulse_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence accept_s;  instr_ready && instr_valid; endsequence
   sequence classify_s; state_q == ST_DECODE ##1 state_q != ST_DECODE; endsequence

   instr_decode_a: assert property (accept_s |=> classify_s ##[1:3] instr_done)
      else $error("Accepted opcode not decoded and finished in time.");
   rmw_store_a: assert property (rmw_ok && rmw_mem && alu_wb
      |=> mem_wr && mem_wdata == $past(alu_res) && mem_addr == $past(addr_q))
      else $error("Modified operand not written back to its address.");
   test_nowrite_a: assert property (rmw_ok && lo == FN_TEST |=> !mem_wr ##1 !mem_wr)
      else $error("Test operation wrote its operand.");
   bit_carry_a: assert property (exec_st && cls_q == CL_BIT_TEST
      |=> ccr[0] == $past(tested))
      else $error("Tested bit not copied into carry.");
   bit_modify_a: assert property (exec_st && cls_q == CL_BIT_MOD
      |=> mem_wr && mem_wdata[$past(bit_sel)] == !$past(op_q[0]))
      else $error("Selected bit not set or cleared.");
   branch_never_a: assert property (exec_st && cls_q == CL_BRANCH && lo == COND_NEVER
      |=> !branch_taken && pc_out == $past(pcn_q))
      else $error("Branch never changed the flow.");
   branch_always_a: assert property (exec_st && cls_q == CL_BRANCH && lo == COND_ALWAYS
      |=> branch_taken && pc_out == $past(target))
      else $error("Branch always not taken.");
   irq_branch_a: assert property (exec_st && cls_q == CL_BRANCH && lo == COND_IRQ_HI
      |=> branch_taken == $past(irq_line))
      else $error("Interrupt line branch wrong.");
   carry_set_a: assert property (ctl && op_q == OP_CARRY1 |=> ccr[0] ##1 instr_ready)
      else $error("Carry not set.");

endmodule : mpu_exec_core

// >>> mem_model.sv
`timescale 1ns/1ps
module mem_model (
   input  wire logic                     sys_clk,
   input  wire logic                     mem_rd,
   input  wire logic                     mem_wr,
   input  wire logic [mpu_pkg::MA_W-1:0] mem_addr,
   input  wire logic [7:0]               mem_wdata,
   output logic      [7:0]               mem_rdata
);
   import mpu_pkg::*;
   logic [7:0] mem [0:(1<<MA_W)-1];
   logic [7:0] rd_q = 8'hA5;
   assign mem_rdata = rd_q;
   // Read data holds only for the cycle after the strobe; it toggles otherwise, so a late sample fails.
   always @(posedge sys_clk) begin
      if (mem_rd) rd_q <= mem[mem_addr];
      else rd_q <= ~rd_q;
      if (mem_wr) mem[mem_addr] <= mem_wdata;
   end
endmodule : mem_model

// >>> tb_eight_bit_mpu_instruction_semantics.sv
`timescale 1ns/1ps
module tb_eight_bit_mpu_instruction_semantics;
   import mpu_pkg::*;
   localparam logic [3:0] FNS [11] = '{FN_NEGATE, FN_COM, FN_SHR, FN_ROT_R, FN_SHR_ARITH, FN_SHL,
                                       FN_ROT_L, FN_MINUS_ONE, FN_INC, FN_TEST, FN_ZERO};
   localparam logic [7:0] CTLS [13] = '{OP_RET_INT, OP_RTS, OP_TRAP, OP_STOP, OP_WAIT, OP_A_TO_X,
                                        OP_CARRY0, OP_CARRY1, OP_MASK0, OP_MASK1, OP_SP_RESET,
                                        OP_IDLE, OP_X_TO_A};
   localparam logic [7:0] DIR [22] = '{8'h4F, 8'h4A, 8'h97, 8'h4C, 8'h99, 8'h22, 8'h25, 8'h28,
                                       8'h29, 8'h2D, 8'h8F, 8'h2C, 8'h83, 8'h2D, 8'h2E, 8'h2F,
                                       8'h9F, 8'h9C, 8'h20, 8'h21, 8'hAD, 8'hB6};
   logic            sys_clk = 1'b0;
   logic            rst_n = 1'b0;
   logic            instr_valid = 1'b0;
   logic [7:0]      opcode = 8'h9D;
   logic [7:0]      ea_in = 8'h00;
   logic [7:0]      rel_in = 8'h00;
   logic [PC_W-1:0] pc_next_in = '0;
   logic            irq_line = 1'b0;
   logic            instr_ready, instr_done, branch_taken, mem_rd, mem_wr;
   logic            trap_req, ret_sub_req, ret_int_req, stop_req, wait_req, unsupported;
   logic [PC_W-1:0] pc_out;
   logic [MA_W-1:0] mem_addr;
   logic [7:0]      mem_wdata, mem_rdata, acc, idx, sp, m_acc, m_idx, m_sp;
   logic [4:0]      ccr, m_ccr;
   logic [31:0]     seed = 32'h14022987;
   logic [7:0]      op;
   int              error_cnt = 0;
   int              checks = 0;

   mpu_exec_core i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid),
      .opcode(opcode), .ea_in(ea_in), .rel_in(rel_in), .pc_next_in(pc_next_in),
      .irq_line(irq_line), .mem_rdata(mem_rdata), .instr_ready(instr_ready),
      .instr_done(instr_done), .pc_out(pc_out), .branch_taken(branch_taken), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .acc(acc), .idx(idx),
      .sp(sp), .ccr(ccr), .trap_req(trap_req), .ret_sub_req(ret_sub_req),
      .ret_int_req(ret_int_req), .stop_req(stop_req), .wait_req(wait_req),
      .unsupported(unsupported));
   mem_model i_mem (.sys_clk(sys_clk), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   initial begin
      forever #10 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // Returns the new carry above the result byte.
   function automatic logic [8:0] rmw_exp(input logic [3:0] fn, input logic [7:0] v, input logic c);
      case (fn)
         FN_NEGATE: return {v != 8'h00, 8'h00 - v};
         FN_COM: return {1'b1, ~v};
         FN_SHR: return {v[0], 1'b0, v[7:1]};
         FN_ROT_R: return {v[0], c, v[7:1]};
         FN_SHR_ARITH: return {v[0], v[7], v[7:1]};
         FN_SHL: return {v[7], v[6:0], 1'b0};
         FN_ROT_L: return {v[7], v[6:0], c};
         FN_MINUS_ONE: return {c, v - 8'h01};
         FN_INC: return {c, v + 8'h01};
         FN_TEST: return {c, v};
         default: return {c, 8'h00};
      endcase
   endfunction : rmw_exp

   function automatic logic cond(input logic [3:0] k, input logic [4:0] f, input logic irq);
      logic r;
      case (k[3:1])
         3'd0: r = 1'b1;
         3'd1: r = ~(f[0] | f[1]);
         3'd2: r = ~f[0];
         3'd3: r = ~f[1];
         3'd4: r = ~f[4];
         3'd5: r = ~f[2];
         3'd6: r = ~f[3];
         default: r = ~irq;
      endcase
      return r ^ k[0];
   endfunction : cond

   task automatic finish_test;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   task automatic step(input logic [7:0] o);
      logic [7:0] v, r;
      logic [8:0] a;
      logic [4:0] pul;
      logic       tk, br, wr, rd, un;
      int         lat, n, nrd, nwr;
      @(negedge sys_clk);
      seed = lfsr(seed);
      opcode = o;
      ea_in = seed[7:0];
      rel_in = seed[15:8];
      pc_next_in = seed[28:16];
      irq_line = seed[31];
      a = (o[7:4] == 4'h6) ? {1'b0, m_idx} + {1'b0, seed[7:0]} : {1'b0, seed[7:0]};
      v = (o[7:4] == 4'h4) ? m_acc : i_mem.mem[a];
      r = v;
      {tk, br, wr, un, pul, lat} = {4'b0000, 5'h00, 3};
      rd = o[7:4] inside {4'h0, 4'h1, 4'h3, 4'h6};
      case (o[7:4])
         4'h0: {br, tk, m_ccr[0], lat} = {1'b1, v[o[3:1]] ^ o[0], v[o[3:1]], 4};
         4'h1: {r[o[3:1]], wr, lat} = {~o[0], 1'b1, 5};
         4'h2: {br, tk} = {1'b1, cond(o[3:0], m_ccr, seed[31])};
         4'h3, 4'h4, 4'h6: begin
            {m_ccr[0], r} = rmw_exp(o[3:0], v, m_ccr[0]);
            m_ccr[2:1] = {r[7], r == 8'h00};
            wr = (o[3:0] != FN_TEST) && (o[7:4] != 4'h4);
            lat = (o[7:4] == 4'h4) ? 3 : (wr ? 5 : 4);
            if (o[7:4] == 4'h4) m_acc = r;
         end
         default: case (o)
            OP_TRAP: {pul[4], m_ccr[3]} = 2'b11;
            OP_RTS: pul[3] = 1'b1;
            OP_RET_INT: pul[2] = 1'b1;
            OP_STOP: pul[1] = 1'b1;
            OP_WAIT: {pul[0], m_ccr[3]} = 2'b10;
            OP_A_TO_X: m_idx = m_acc;
            OP_X_TO_A: m_acc = m_idx;
            OP_CARRY0, OP_CARRY1: m_ccr[0] = o[0];
            OP_MASK0, OP_MASK1: m_ccr[3] = o[0];
            OP_SP_RESET: m_sp = SP_INIT;
            OP_BSR: {br, tk} = 2'b11;
            OP_IDLE: ;
            default: un = 1'b1;
         endcase
      endcase
      instr_valid = 1'b1;
      n = 0;
      while (instr_ready !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      {n, nrd, nwr} = {32'd0, 32'd0, 32'd0};
      do begin
         @(negedge sys_clk);
         instr_valid = 1'b0;
         n++;
         nrd += int'(mem_rd === 1'b1);
         nwr += int'(mem_wr === 1'b1);
      end while (instr_done !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         finish_test();
      end
      chk(n, lat);
      chk({nrd, nwr}, {31'd0, rd, 31'd0, wr});
      chk({unsupported, trap_req, ret_sub_req, ret_int_req, stop_req, wait_req}, {un, pul});
      chk({acc, idx, sp, ccr}, {m_acc, m_idx, m_sp, m_ccr});
      if (br) chk({branch_taken, pc_out}, {tk, tk ? seed[28:16] + {{5{seed[15]}}, seed[15:8]} : seed[28:16]});
      if (wr) chk(i_mem.mem[a], r);
   endtask : step

   initial begin
      for (int k = 0; k < (1 << MA_W); k++) begin
         seed = lfsr(seed);
         i_mem.mem[k] = seed[7:0];
      end
      {m_acc, m_idx, m_sp, m_ccr} = {ACC_RESET, IDX_RESET, SP_INIT, 1'b0, MASK_RESET, 3'b000};
      repeat (5) @(negedge sys_clk);
      chk({instr_ready, acc, idx, sp, ccr}, {1'b1, m_acc, m_idx, m_sp, m_ccr});
      rst_n = 1'b1;
      // Directed corners first: byte wrap on decrement, flag-driven branches, trap and wait.
      foreach (DIR[k]) step(DIR[k]);
      for (int k = 0; k < 600; k++) begin
         seed = lfsr(seed);
         case (seed[2:0])
            3'd0, 3'd1: op = {3'b000, seed[3], seed[7:4]};
            3'd2: op = {4'h2, seed[7:4]};
            3'd3: op = CTLS[int'(seed[7:4]) % 13];
            default: op = {seed[3] ? 4'h4 : (seed[4] ? 4'h6 : 4'h3), FNS[int'(seed[8:5]) % 11]};
         endcase
         step(op);
      end
      finish_test();
   end
endmodule : tb_eight_bit_mpu_instruction_semantics
